// ==== gpio_pin_control_bank.v ====
// Four-pin control bank with serial port four alternate functions
`timescale 1ns/10ps
`include "gpio_pin_control_bank_regs.vh"
module gpio_pin_control_bank #(
  parameter LARGE_VARIANT = 1
) (
  // Clock and reset
  input  wire       i_clock,
  input  wire       i_rst,
  // Register port
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  // Pins
  input  wire [3:0] i_pin,
  output reg  [3:0] o_pin,
  output reg  [3:0] o_pin_oe,
  // Serial port four
  output reg        o_serial4_receive_input,
  input  wire       i_serial4_transmit_output,
  output reg        o_serial4_set_ready_input,
  input  wire       i_serial4_request_send_output
);

  // Control byte bits that exist in this variant
  localparam [7:0] CTRL_MASK  = LARGE_VARIANT ? `CTRL_MASK_LARGE : `CTRL_MASK_SMALL;
  // Alternate pins 1 and 3 are outputs, 0 and 2 inputs
  localparam [3:0] ALT_DRIVES = 4'hA;
  // Test register bits that software may store
  localparam [7:0] TEST_MASK  = `FACTORY_TEST_WR_MASK;

  // Write decode
  wire       wr_test;
  wire       wr_data;
  wire [3:0] wr_ctrl;

  // Per-pin results of the generate loop
  wire [3:0] pin_out_w;
  wire [3:0] pin_oe_w;
  wire [3:0] is_alt;
  wire [3:0] alt_out;
  wire [3:0] in_levels;

  // Held state, plus the combinational input word and read data
  reg  [7:0] test_q;
  reg  [3:0] gpio_out_q;
  reg  [3:0] gpio_in_d;
  reg  [7:0] rdata_d;

  // Index of a pin control offset, 4 when not a pin control
  function [2:0] pin_index;
    input [7:0] a;
    begin
      if (a >= `PORT6_PIN4_CONTROL_OFS && a <= `PORT6_PIN7_CONTROL_OFS)
      begin
        pin_index = a[2:0] - 3'h6;
      end
      else
      begin
        pin_index = 3'h4;
      end
    end
  endfunction

  // Level after the polarity select, used on both pin paths
  function apply_polarity;
    input value;
    input invert;
    begin
      apply_polarity = value ^ invert;
    end
  endfunction

  assign wr_test = i_wr && (i_addr == `FACTORY_TEST_OFS);
  assign wr_data = i_wr && (i_addr == `GPIO_DATA_OFS);

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : pin
      reg  [7:0] ctrl_q;
      reg        out_d;
      reg        oe_d;
      reg        in_q;
      wire       dir_in;
      wire       pol_inv;
      wire       alt_sel;
      wire       odrain;
      wire       level;

      assign wr_ctrl[g] = i_wr && (pin_index(i_addr) == g);

      // Control byte, reserved bits kept at zero
      always @(posedge i_clock or posedge i_rst)
      begin
        if (i_rst)
        begin
          ctrl_q <= `PIN_CTRL_RESET;
        end
        else if (wr_ctrl[g])
        begin
          ctrl_q <= i_wdata & CTRL_MASK;
        end
      end

      // Pin level sampled once a cycle
      always @(posedge i_clock or posedge i_rst)
      begin
        if (i_rst)
        begin
          in_q <= 1'b0;
        end
        else
        begin
          in_q <= i_pin[g];
        end
      end

      assign dir_in  = ctrl_q[`CTRL_DIR_BIT];
      assign pol_inv = ctrl_q[`CTRL_POL_BIT];
      assign alt_sel = (LARGE_VARIANT != 0) && ctrl_q[`CTRL_ALT_BIT];
      assign odrain  = ctrl_q[`CTRL_ODRAIN_BIT];
      assign level   = apply_polarity(gpio_out_q[g], pol_inv);
      // Input seen by software, cut off while the alternate function owns the pin
      assign in_levels[g] = apply_polarity(in_q, pol_inv) & ~alt_sel;
      assign is_alt[g]    = alt_sel;

      // Serial port four outputs reach pins 1 and 3 only
      if (g == 1)
      begin : tx_route
        assign alt_out[g] = i_serial4_transmit_output;
      end
      else if (g == 3)
      begin : rts_route
        assign alt_out[g] = i_serial4_request_send_output;
      end
      else
      begin : no_route
        assign alt_out[g] = 1'b0;
      end

      // Driver select: alternate, input, open drain or push-pull
      always @*
      begin
        out_d = 1'b0;
        oe_d  = 1'b0;
        if (alt_sel)
        begin
          out_d = alt_out[g];
          oe_d  = ALT_DRIVES[g];
        end
        else if (dir_in)
        begin
          out_d = 1'b0;
          oe_d  = 1'b0;
        end
        else if (odrain)
        begin
          // Pulls low only and lets the pin float for a high level
          out_d = 1'b0;
          oe_d  = ~level;
        end
        else
        begin
          out_d = level;
          oe_d  = 1'b1;
        end
      end

      assign pin_out_w[g] = out_d;
      assign pin_oe_w[g]  = oe_d;
    end
  endgenerate

  // Pin outputs follow the driver select
  always @*
  begin
    o_pin    = pin_out_w;
    o_pin_oe = pin_oe_w;
  end

  // Test register keeps only its storable bits
  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      test_q <= `FACTORY_TEST_RESET;
    end
    else if (wr_test)
    begin
      test_q <= i_wdata & TEST_MASK;
    end
  end

  // Output value register
  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      gpio_out_q <= 4'h0;
    end
    else if (wr_data)
    begin
      gpio_out_q <= i_wdata[3:0];
    end
  end

  // Input word of the data register
  always @*
  begin
    gpio_in_d = in_levels;
  end

  // Serial receive input, idle high while the pin is plain GPIO
  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_serial4_receive_input <= 1'b1;
    end
    else if (is_alt[0])
    begin
      o_serial4_receive_input <= i_pin[0];
    end
    else
    begin
      o_serial4_receive_input <= 1'b1;
    end
  end

  // Serial set-ready input, idle high while the pin is plain GPIO
  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_serial4_set_ready_input <= 1'b1;
    end
    else if (is_alt[2])
    begin
      o_serial4_set_ready_input <= i_pin[2];
    end
    else
    begin
      o_serial4_set_ready_input <= 1'b1;
    end
  end

  // Read multiplexer
  always @*
  begin
    rdata_d = 8'h00;
    case (pin_index(i_addr))
      3'h0:
      begin
        rdata_d = pin[0].ctrl_q;
      end
      3'h1:
      begin
        rdata_d = pin[1].ctrl_q;
      end
      3'h2:
      begin
        rdata_d = pin[2].ctrl_q;
      end
      3'h3:
      begin
        rdata_d = pin[3].ctrl_q;
      end
      default:
      begin
        if (i_addr == `FACTORY_TEST_OFS)
        begin
          rdata_d = test_q;
        end
        else if (i_addr == `GPIO_DATA_OFS)
        begin
          rdata_d = {4'h0, gpio_in_d};
        end
        else
        begin
          rdata_d = 8'h00;
        end
      end
    endcase
  end

  // Read data stand for the one cycle after the strobe
  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rdata <= 8'h00;
    end
    else if (i_rd)
    begin
      o_rdata <= rdata_d;
    end
    else
    begin
      o_rdata <= 8'h00;
    end
  end

endmodule // gpio_pin_control_bank

// ==== gpio_pin_control_bank_regs.vh ====
// Register offsets, fields and reset values of the pin control bank
// Summary of operation
// - Bit 0 one means input, zero output
// - Bit 1 one inverts pin value
// - Bit 7 one open-drain, zero push-pull
// - Reset loads every pin control with 01
// - Bit 2 routes pins to serial four
// - Small variant reserves bits 6:2, else 6:3
// - Test bits 2-4,6,7 read-only, writes ignored
`ifndef GPIO_PIN_CONTROL_BANK_REGS_VH
`define GPIO_PIN_CONTROL_BANK_REGS_VH
`define PORT6_PIN4_CONTROL_OFS 8'h56
`define PORT6_PIN5_CONTROL_OFS 8'h57
`define PORT6_PIN6_CONTROL_OFS 8'h58
`define PORT6_PIN7_CONTROL_OFS 8'h59
`define FACTORY_TEST_OFS       8'h5A
`define GPIO_DATA_OFS          8'h60
`define PIN_CTRL_RESET         8'h01
`define FACTORY_TEST_RESET     8'h00
`define FACTORY_TEST_WR_MASK   8'h23
`define CTRL_DIR_BIT           0
`define CTRL_POL_BIT           1
`define CTRL_ALT_BIT           2
`define CTRL_ODRAIN_BIT        7
`define CTRL_MASK_LARGE        8'h87
`define CTRL_MASK_SMALL        8'h83
`endif

// ==== gpio_ctl_props_properties.sv ====
// Port assertions for the pin control bank
`timescale 1ns/10ps
module gpio_ctl_props (
  input wire i_clock, i_rst, i_wr, i_rd, i_serial4_transmit_output, o_serial4_receive_input,
  input wire i_serial4_request_send_output, o_serial4_set_ready_input,
  input wire [7:0] i_addr, i_wdata, o_rdata,
  input wire [3:0] i_pin, o_pin, o_pin_oe);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence w(a, d); i_wr && i_addr == a && i_wdata == d; endsequence
  a_dir_input: assert property (w(8'h56, 8'h01) |=> !o_pin_oe[0]) else $error("oe");
  a_pol_invert: assert property (w(8'h56, 8'h02) ##2 (i_wr && i_addr == 8'h60)
    |=> o_pin[0] != $past(i_wdata[0])) else $error("pol");
  a_open_drain: assert property (w(8'h56, 8'h80) |=> !o_pin[0]) else $error("od");
  a_alt_rts: assert property (w(8'h59, 8'h04)
    |=> o_pin_oe[3] && o_pin[3] == i_serial4_request_send_output) else $error("rts");
  a_alt_dsr: assert property (w(8'h58, 8'h04) |=> ##1 o_serial4_set_ready_input == $past(i_pin[2]))
    else $error("dsr");
  a_reset_state: assert property ($fell(i_rst) |-> !o_pin_oe && o_serial4_receive_input) else $error("rst");
  a_alt_tx: assert property (w(8'h57, 8'h04)
    |=> o_pin_oe[1] && o_pin[1] == i_serial4_transmit_output) else $error("tx");
  a_alt_rx: assert property (w(8'h56, 8'h04) |=> ##1 o_serial4_receive_input == $past(i_pin[0]))
    else $error("rx");
  a_ctrl_reserved: assert property (i_rd && i_addr >= 8'h56 && i_addr <= 8'h59
    |=> !(o_rdata & 8'h78)) else $error("rsv");
  a_test_readonly: assert property (i_rd && i_addr == 8'h5A |=> !(o_rdata & 8'hDC)) else $error("ro");
endmodule // gpio_ctl_props
bind gpio_pin_control_bank gpio_ctl_props u_gpio_ctl_props (.i_clock(i_clock), .i_rst(i_rst),
  .i_wr(i_wr), .i_rd(i_rd), .i_serial4_transmit_output(i_serial4_transmit_output),
  .o_serial4_receive_input(o_serial4_receive_input),
  .i_serial4_request_send_output(i_serial4_request_send_output),
  .o_serial4_set_ready_input(o_serial4_set_ready_input), .i_addr(i_addr), .i_wdata(i_wdata),
  .o_rdata(o_rdata), .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe));

// ==== pin_board_model.sv ====
// Board side of the four pins
`timescale 1ns/10ps
module pin_board_model (input wire [3:0] i_level, i_drive, i_oe, output wire [3:0] o_wire);
  assign o_wire = i_oe & i_drive | ~i_oe & i_level;
endmodule // pin_board_model

// ==== testbench.sv ====
// Bench for the pin control bank
`timescale 1ns/10ps
module testbench;
  reg i_clock=0, i_rst=1, i_wr=0, i_rd=0, i_serial4_transmit_output=0, i_serial4_request_send_output=1;
  reg [7:0] i_addr=0, i_wdata=0;
  reg [3:0] ext=4'hF;
  wire [7:0] o_rdata;
  wire [3:0] i_pin, o_pin, o_pin_oe;
  wire o_serial4_receive_input, o_serial4_set_ready_input;
  integer errors=0, n_checks=0;
  always #2 i_clock=~i_clock;
  pin_board_model u_pin_board_model (.i_level(ext), .i_drive(o_pin), .i_oe(o_pin_oe), .o_wire(i_pin));
  gpio_pin_control_bank u_gpio_pin_control_bank (
    .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
    .o_serial4_receive_input(o_serial4_receive_input),
    .i_serial4_transmit_output(i_serial4_transmit_output),
    .o_serial4_set_ready_input(o_serial4_set_ready_input),
    .i_serial4_request_send_output(i_serial4_request_send_output));
  task drv(input [3:0] v);
    @(posedge i_clock) ext <= v;
  endtask
  task c(input [63:0] n, input [7:0] e, g);
    n_checks++;
    if (g!==e) begin errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end
  endtask
  task wr(input [7:0] a, d);
    @(posedge i_clock) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clock) i_wr <= 0;
    #1;
  endtask
  task rd(input [7:0] a, e);
    @(posedge i_clock) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clock) i_rd <= 0;
    #1 c("rd", e, o_rdata);
  endtask
  task stop_test;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors==0 && n_checks>0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin #4000 errors++; stop_test; end
  initial begin
    repeat (4) @(posedge i_clock);
    i_rst <= 0;
    rd(8'h59, 8'h01);
    c("oe", 8'h00, o_pin_oe);
    wr(8'h56, 8'hFF); rd(8'h56, 8'h87);
    wr(8'h5A, 8'hDC); rd(8'h5A, 8'h00);
    wr(8'h60, 8'h01);
    wr(8'h56, 8'h00);
    c("pp", 8'h03, {o_pin_oe[0], o_pin[0]});
    wr(8'h56, 8'h02);
    wr(8'h60, 8'h01);
    c("pol", 8'h02, {o_pin_oe[0], o_pin[0]});
    wr(8'h56, 8'h80);
    c("odh", 8'h00, {o_pin_oe[0], o_pin[0]});
    c("pin", 8'h01, i_pin[0]);
    wr(8'h60, 8'h00);
    c("odl", 8'h02, {o_pin_oe[0], o_pin[0]});
    wr(8'h56, 8'h01);
    c("in", 8'h00, {o_pin_oe[0], o_pin[0]});
    drv(4'hD); wr(8'h57, 8'h03); rd(8'h60, 8'h0F);
    wr(8'h57, 8'h04); c("tx", 1, o_pin_oe[1] & ~o_pin[1]);
    drv(4'hE); wr(8'h56, 8'h04); rd(8'h60, 8'h0C);
    c("rx", 0, o_serial4_receive_input);
    wr(8'h59, 8'h04);
    c("rts", 8'h03, {o_pin_oe[3], o_pin[3]});
    drv(4'h0);
    wr(8'h58, 8'h04);
    @(posedge i_clock);
    #1;
    c("dsr", 8'h00, o_serial4_set_ready_input);
    rd(8'h80, 8'h00);
    @(posedge i_clock) i_rst <= 1;
    @(posedge i_clock) i_rst <= 0;
    rd(8'h58, 8'h01);
    c("oe2", 8'h00, o_pin_oe);
    c("rx2", 8'h01, o_serial4_receive_input);
    stop_test;
  end
endmodule // testbench
